//--- include/vmb_pkg.sv
// shared constants, types and helpers of the mailbox / broadcast / interrupt combiner
package vmb_pkg;

    // *****************************************************************
    // sizes
    // *****************************************************************
    localparam int NUM_MBX   = 8;
    localparam int NUM_SRC   = 42;
    localparam int NUM_LOCAL = 23;
    localparam int NUM_VIRQ  = 7;
    localparam int BOARDS    = 20;
    localparam int LVL_W     = 3;
    localparam int LVL_WORDS = 6;
    localparam int ST_W      = 11;
    localparam int AXI_AW    = 8;

    // source numbering inside the combiner
    localparam int SRC_CH0   = 8;
    localparam int SRC_CH1   = 9;
    localparam int SRC_VIRQ  = 10;
    localparam int SRC_ACF   = 17;
    localparam int SRC_SYSF  = 18;
    localparam int SRC_LOCAL = 19;

    // status bit positions
    localparam int ST_CH0 = 8;
    localparam int ST_CH1 = 9;
    localparam int ST_OVF = 10;

    // *****************************************************************
    // register byte offsets
    // *****************************************************************
    localparam logic [7:0] OFF_STAT  = 8'h00;
    localparam logic [7:0] OFF_MASK  = 8'h04;
    localparam logic [7:0] OFF_VBASE = 8'h08;
    localparam logic [7:0] OFF_SLOT  = 8'h0c;
    localparam logic [7:0] OFF_FIFO0 = 8'h10;
    localparam logic [7:0] OFF_FIFO1 = 8'h14;
    localparam logic [7:0] OFF_EXTV  = 8'h18;
    localparam logic [7:0] OFF_PENDL = 8'h1c;
    localparam logic [7:0] OFF_PENDH = 8'h20;
    localparam logic [7:0] OFF_LVL0  = 8'h40;

    localparam logic [7:0] VBASE_RST = 8'h40;
    localparam int         SLOT_EN   = 5;
    localparam logic [7:0] VEC_STEP  = 8'h01;
    localparam logic [1:0] RESP_OK   = 2'h0;
    localparam logic [1:0] RESP_ERR  = 2'h2;

    // *****************************************************************
    // bus-side decode
    // *****************************************************************
    localparam logic [7:0] BC_PAGE     = 8'hfa;
    localparam logic [7:0] MBX_PAGE    = 8'hfd;
    localparam int         BC_MASK_LSB = 2;
    localparam int         BC_CH_BIT   = 22;
    localparam logic [2:0] AM_A32      = 3'h1;

    typedef struct packed {
        logic [31:0] addr;
        logic [5:0]  am;
        logic [7:0]  data;
        logic        write;
        logic        lock;
    } vmb_vme_s;

    typedef enum logic [1:0] {VEC_NONE, VEC_INTERNAL, VEC_LOCAL, VEC_VME} vmb_vec_e;

    typedef struct packed {
        logic       done;
        vmb_vec_e   src;
        logic [7:0] vector;
    } vmb_iack_s;

    function automatic logic isA32(input logic [5:0] am);
        return am[5:3] == AM_A32;
    endfunction

endpackage

//--- design/vmb_msg_fifo.sv
// byte message store for one broadcast channel
`timescale 1ns/100ps
`default_nettype none
module vmb_msg_fifo
    import vmb_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             wrValid,
    input  wire logic [WIDTH-1:0] wrData,
    output logic                  wrReady,
    output logic                  rdValid,
    output logic [WIDTH-1:0]      rdData,
    input  wire logic             rdReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [CW-1:0]    count_reg;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign wrReady = (count_reg != CW'(DEPTH));
    assign rdValid = (count_reg != '0);
    assign rdData  = mem_reg[rdPtr_reg];
    // a push into a full store is refused so stored entries stay intact
    assign push    = wrValid & wrReady;
    assign pop     = rdValid & rdReady;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wrPtr_reg] <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= bump(wrPtr_reg);
            end
            if (pop) begin
                rdPtr_reg <= bump(rdPtr_reg);
            end
            count_reg <= count_reg + CW'(push) - CW'(pop);
        end
    end
endmodule
`default_nettype wire

//--- design/vmb_mailbox_irq.sv
// mailboxes, broadcast channels and interrupt combiner with an AXI4-Lite register port
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - eight mailboxes, each raises a processor interrupt when its mask bit is set
// - per-mailbox level and individual acknowledge vector
// - mailboxes served only by locked RMW cycles
// - slave accesses decoded with 32-bit addressing only
// - one write reaches any subset of twenty
// - addressed receiver captures byte, raises interrupt
// - channel zero queues eight bytes, independently
// - channel one holds exactly one byte
// - every source gets level one to seven
// - local and seven bus requests are merged
// - power and system failure add; forty-two total
// - acknowledge supplies vector or starts a fetch
// - internal vector is base plus fixed increment
module vmb_mailbox_irq
    import vmb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              vmeStrobe,
    input  wire vmb_vme_s          vmeCycle,
    output logic                   vmeAck,
    output logic [7:0]             vmeRdData,
    input  wire logic [6:0]        vmeIrqN,
    input  wire logic              acFailN,
    input  wire logic              sysFailN,
    input  wire logic [22:0]       localIrq,
    input  wire logic              iackReq,
    input  wire logic [2:0]        iackLevel,
    output vmb_iack_s              iackOut,
    output logic [2:0]             ipl,
    output logic                   irq
);
    // *****************************************************************
    // pin synchronisers
    // *****************************************************************
    vmb_vme_s    cycS1_reg, cycS2_reg;
    logic [2:0]  stb_reg;
    logic [8:0]  pinS1_reg, pinS2_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cycS1_reg <= '0;
            cycS2_reg <= '0;
            stb_reg   <= '0;
            pinS1_reg <= '0;
            pinS2_reg <= '0;
        end else begin
            cycS1_reg <= vmeCycle;
            cycS2_reg <= cycS1_reg;
            stb_reg   <= {stb_reg[1:0], vmeStrobe};
            pinS1_reg <= ~{sysFailN, acFailN, vmeIrqN};
            pinS2_reg <= pinS1_reg;
        end
    end

    // *****************************************************************
    // bus slave decode
    // *****************************************************************
    logic [ST_W-1:0]   stat_reg, mask_reg;
    logic [7:0]        vbase_reg;
    logic [5:0]        slot_reg;
    logic [NUM_LOCAL-1:0] extv_reg;
    logic [LVL_W-1:0]  lvl_reg [NUM_SRC];
    logic              served_reg;
    logic [7:0]        vmeRd_reg;
    logic              vmeStart, a32, bcHit, mbxHit, srv, chSel;
    logic [BOARDS-1:0] bcMask;
    logic [2:0]        mbxIdx;
    logic [NUM_MBX-1:0] mbxSet;

    assign vmeStart = stb_reg[1] & ~stb_reg[2];
    assign a32      = isA32(cycS2_reg.am);
    assign bcMask   = cycS2_reg.addr[BC_MASK_LSB +: BOARDS];
    assign chSel    = cycS2_reg.addr[BC_CH_BIT];
    assign mbxIdx   = cycS2_reg.addr[4:2];
    // one address bit per receiver, so any subset is reached in one write
    assign bcHit = a32 & cycS2_reg.write & (cycS2_reg.addr[31:24] == BC_PAGE)
                 & slot_reg[SLOT_EN] & (slot_reg[4:0] < 5'(BOARDS))
                 & bcMask[slot_reg[4:0]];
    assign mbxHit = a32 & (cycS2_reg.addr[31:24] == MBX_PAGE)
                  & (cycS2_reg.addr[23:5] == '0);
    // unlocked mailbox cycles get no acknowledge so a sharer cannot race
    assign srv    = vmeStart & (bcHit | (mbxHit & cycS2_reg.lock));

    always_comb begin
        mbxSet = '0;
        if (srv && mbxHit && cycS2_reg.write) begin
            mbxSet[mbxIdx] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            served_reg <= 1'b0;
            vmeRd_reg  <= '0;
        end else begin
            if (srv) begin
                served_reg <= 1'b1;
            end else if (!stb_reg[1]) begin
                served_reg <= 1'b0;
            end
            // read half of the locked cycle returns the pending flag
            if (srv && mbxHit && !cycS2_reg.write) begin
                vmeRd_reg <= {7'h0, stat_reg[mbxIdx]};
            end
        end
    end

    assign vmeAck    = served_reg;
    assign vmeRdData = vmeRd_reg;

    // *****************************************************************
    // broadcast channels
    // *****************************************************************
    logic       wr0, wr1, rdy0, rdy1, val0, val1, pop0, pop1;
    logic [7:0] dat0, dat1;

    assign wr0 = srv & bcHit & ~chSel;
    assign wr1 = srv & bcHit & chSel;

    vmb_msg_fifo #(.WIDTH(8), .DEPTH(8)) u_ch0 (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wrValid (wr0),
        .wrData  (cycS2_reg.data),
        .wrReady (rdy0),
        .rdValid (val0),
        .rdData  (dat0),
        .rdReady (pop0)
    );

    vmb_msg_fifo #(.WIDTH(8), .DEPTH(1)) u_ch1 (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wrValid (wr1),
        .wrData  (cycS2_reg.data),
        .wrReady (rdy1),
        .rdValid (val1),
        .rdData  (dat1),
        .rdReady (pop1)
    );

    // *****************************************************************
    // register port
    // *****************************************************************
    logic        wrGo, arGo, bvalid_reg, rvalid_reg, rdMapped;
    logic [1:0]  bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, rdWord;
    logic [7:0]  wa, ra;
    logic [ST_W-1:0] w1c, stSet;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic isLvl(input logic [7:0] a);
        return (a >= OFF_LVL0) && (a < OFF_LVL0 + 8'(4 * LVL_WORDS));
    endfunction

    assign wa = s_axi_awaddr;
    assign ra = s_axi_araddr;
    assign wrGo = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
    assign arGo = s_axi_arvalid & ~rvalid_reg;
    assign s_axi_awready = wrGo;
    assign s_axi_wready  = wrGo;
    assign s_axi_arready = ~rvalid_reg;
    assign pop0 = arGo & (ra == OFF_FIFO0);
    assign pop1 = arGo & (ra == OFF_FIFO1);
    assign w1c  = (wrGo && wa == OFF_STAT) ? ST_W'(merge('0, s_axi_wdata, s_axi_wstrb)) : '0;
    assign stSet = {wr0 & ~rdy0, wr1, wr0, mbxSet};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= (stat_reg & ~w1c) | stSet;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask_reg  <= '0;
            vbase_reg <= VBASE_RST;
            slot_reg  <= '0;
            extv_reg  <= '0;
            for (int i = 0; i < NUM_SRC; i++) begin
                lvl_reg[i] <= '0;
            end
        end else if (wrGo) begin
            if (wa == OFF_MASK) mask_reg <= ST_W'(merge(32'(mask_reg), s_axi_wdata, s_axi_wstrb));
            if (wa == OFF_VBASE) vbase_reg <= 8'(merge(32'(vbase_reg), s_axi_wdata, s_axi_wstrb));
            if (wa == OFF_SLOT) slot_reg <= 6'(merge(32'(slot_reg), s_axi_wdata, s_axi_wstrb));
            if (wa == OFF_EXTV) begin
                extv_reg <= NUM_LOCAL'(merge(32'(extv_reg), s_axi_wdata, s_axi_wstrb));
            end
            for (int i = 0; i < NUM_SRC; i++) begin
                if (isLvl(wa) && (wa[4:2] == 3'(i / 8)) && s_axi_wstrb[(i % 8) / 2]) begin
                    lvl_reg[i] <= s_axi_wdata[4 * (i % 8) +: LVL_W];
                end
            end
        end
    end

    // *****************************************************************
    // interrupt combiner
    // *****************************************************************
    logic [NUM_SRC-1:0] pend;
    logic [2:0]         iplNext, ipl_reg;
    logic               found;
    logic [5:0]         hitIdx;
    vmb_iack_s          iack_reg;

    // channel requests follow fill level, not arrival, so unread data keeps asking
    assign pend = {localIrq, pinS2_reg, val1, val0,
                   stat_reg[NUM_MBX-1:0] & mask_reg[NUM_MBX-1:0]};

    always_comb begin
        rdWord   = '0;
        rdMapped = 1'b1;
        if (isLvl(ra)) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (ra[4:2] == 3'(i / 8)) rdWord[4 * (i % 8) +: LVL_W] = lvl_reg[i];
            end
        end else begin
            unique case (ra)
                OFF_STAT:  rdWord = 32'(stat_reg);
                OFF_MASK:  rdWord = 32'(mask_reg);
                OFF_VBASE: rdWord = 32'(vbase_reg);
                OFF_SLOT:  rdWord = 32'(slot_reg);
                OFF_FIFO0: rdWord = {23'h0, val0, dat0};
                OFF_FIFO1: rdWord = {23'h0, val1, dat1};
                OFF_EXTV:  rdWord = 32'(extv_reg);
                OFF_PENDL: rdWord = pend[31:0];
                OFF_PENDH: rdWord = 32'(pend[NUM_SRC-1:32]);
                default:   rdMapped = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OK;
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OK;
            rdata_reg  <= '0;
        end else begin
            if (wrGo) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= (wa == OFF_STAT || wa == OFF_MASK || wa == OFF_VBASE
                           || wa == OFF_SLOT || wa == OFF_EXTV || isLvl(wa)) ? RESP_OK : RESP_ERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (arGo) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rdWord;
                rresp_reg  <= rdMapped ? RESP_OK : RESP_ERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp  = rresp_reg;
    assign s_axi_rdata  = rdata_reg;

    always_comb begin
        iplNext = '0;
        found   = 1'b0;
        hitIdx  = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (pend[i] && lvl_reg[i] > iplNext) iplNext = lvl_reg[i];
        end
        // lowest source number wins among equal levels
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i] && lvl_reg[i] == iackLevel && iackLevel != '0) begin
                found  = 1'b1;
                hitIdx = 6'(i);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ipl_reg  <= '0;
            iack_reg <= '{done: 1'b0, src: VEC_NONE, vector: 8'h00};
        end else begin
            ipl_reg         <= iplNext;
            iack_reg.done   <= iackReq;
            iack_reg.vector <= vbase_reg + 8'(hitIdx * VEC_STEP);
            if (!found) begin
                iack_reg.src <= VEC_NONE;
            end else if (hitIdx >= 6'(SRC_VIRQ) && hitIdx < 6'(SRC_ACF)) begin
                iack_reg.src <= VEC_VME;
            end else if (hitIdx >= 6'(SRC_LOCAL) && extv_reg[5'(hitIdx - 6'(SRC_LOCAL))]) begin
                iack_reg.src <= VEC_LOCAL;
            end else begin
                iack_reg.src <= VEC_INTERNAL;
            end
        end
    end

    assign ipl     = ipl_reg;
    assign iackOut = iack_reg;
    assign irq     = |(stat_reg & mask_reg);

    // *****************************************************************
    // checks
    // *****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_mbx_rmw_set: assert property (srv && mbxHit && cycS2_reg.write |=> stat_reg[$past(mbxIdx)])
        else $error("mailbox write did not set its flag");
    a_mbx_no_lock: assert property (vmeStart && mbxHit && !cycS2_reg.lock && !bcHit |=> !served_reg)
        else $error("unlocked mailbox cycle was acknowledged");
    a_a32_only: assert property (vmeStart && !a32 |=> !served_reg ##1 !served_reg)
        else $error("non-A32 cycle was served");
    a_bcast_capture: assert property (wr0 && rdy0 |=> val0 && stat_reg[ST_CH0])
        else $error("broadcast byte not captured");
    a_full_drop: assert property (wr0 && !rdy0 |=> stat_reg[ST_OVF]
        && (!rdy0 || $past(pop0)))
        else $error("full channel not held on overflow");
    a_ch_pend_lvl: assert property (val1 && lvl_reg[SRC_CH1] != '0
        |=> ipl >= $past(lvl_reg[SRC_CH1]))
        else $error("pending channel one not reflected on level");
    a_ack_vector: assert property (iackReq && found && hitIdx < 6'(SRC_VIRQ)
        |=> iackOut.done && iackOut.src == VEC_INTERNAL
        && iackOut.vector == $past(vbase_reg) + 8'($past(hitIdx)))
        else $error("internal vector wrong");
    a_vme_fetch: assert property (iackReq && found && hitIdx >= 6'(SRC_VIRQ) && hitIdx < 6'(SRC_ACF) |=> iackOut.src == VEC_VME)
        else $error("bus source not fetched from bus");
    a_stat_sticky: assert property (w1c == '0 |=> (($past(stat_reg) & ~stat_reg) == '0))
        else $error("status bit lost without clear");
    a_ipl_zero: assert property (pend == '0 |=> ipl == '0)
        else $error("level raised with nothing pending");

    c_mbx_trigger: cover property (srv && mbxHit && cycS2_reg.write);
    c_bcast_full: cover property (wr0 && !rdy0);
    c_ch1_pop: cover property (pop1 && val1);
    c_iack_local: cover property (iackReq && found ##1 iackOut.src == VEC_LOCAL);
endmodule
`default_nettype wire

//--- tb/vmb_vme_master.sv
// remote bus master model issuing slave cycles to the board
`timescale 1ns/100ps
`default_nettype none
module vmb_vme_master
    import vmb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       vmeAck,
    input  wire logic [7:0] vmeRdData,
    output logic            vmeStrobe,
    output vmb_vme_s        vmeCycle
);
    // ********
    // one strobed cycle, payload set up three clocks ahead
    // ********
    initial begin
        vmeStrobe = 1'h0;
        vmeCycle  = '0;
    end
    task automatic cyc(input logic [31:0] a, input logic [5:0] am, input logic [7:0] d,
                       input logic wr, input logic lk, output logic ok, output logic [7:0] q);
        int n;
        vmeCycle <= '{a, am, d, wr, lk};
        repeat (3) @(posedge clk);
        vmeStrobe <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!vmeAck && n < 12);
        ok = vmeAck;
        q  = vmeRdData;
        vmeStrobe <= 1'h0;
        // released lines show inverted data; lock stays for the write half
        vmeCycle.data <= ~d;
        // at least one edge passes, so the next cycle never re-drives the payload at once
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (vmeAck && n < 12);
    endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench: register port, remote bus cycles, interrupt acknowledge
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import vmb_pkg::*;
;
    localparam logic [31:0] MBX5 = {MBX_PAGE, 19'h0, 3'h5, 2'h0};
    logic clk = 1'h0, sys_rst = 1'h1, iackReq = 1'h0, acFailN = 1'h1, sysFailN = 1'h1;
    // response readies stay high, so back-to-back calls never re-drive them in one step
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1, ok, irq, vmeStrobe, vmeAck;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, q, vmeRdData;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [6:0]  vmeIrqN = 7'h7f;
    logic [22:0] localIrq = '0;
    logic [2:0]  iackLevel = '0, ipl;
    vmb_vme_s    vmeCycle;
    vmb_iack_s   iackOut;
    int          failCount = 0, nTests = 0;
    always #50 clk = ~clk;
    vmb_mailbox_irq DUT (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vmeStrobe, .vmeCycle, .vmeAck, .vmeRdData,
        .vmeIrqN, .acFailN, .sysFailN, .localIrq, .iackReq, .iackLevel, .iackOut, .ipl, .irq);
    vmb_vme_master vme (.clk, .vmeAck, .vmeRdData, .vmeStrobe, .vmeCycle);
    // ********
    // access and compare tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        do @(posedge clk); while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, RESP_OK});
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axr(a, d, r);
        chk(d, e);
    endtask
    task automatic bus(input logic [31:0] a, input logic [5:0] am, input logic [7:0] d,
                       input logic wr, input logic lk, input logic e);
        vme.cyc(a, am, d, wr, lk, ok, q);
        chk({31'h0, ok}, {31'h0, e});
    endtask
    task automatic iak(input logic [2:0] l, input vmb_vec_e s, input logic [7:0] v);
        iackReq <= 1'h1;
        iackLevel <= l;
        @(posedge clk);
        iackReq <= 1'h0;
        @(posedge clk);
        chk(32'(iackOut), 32'({1'h1, s, v}));
    endtask
    function automatic logic [31:0] ba(input logic ch, input logic [19:0] m);
        return {BC_PAGE, 1'h0, ch, m, 2'h0};
    endfunction
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ********
    // test sequence
    // ********
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (6) @(posedge clk);
        sys_rst <= 1'h0;
        rdc(OFF_VBASE, 32'h40);
        axr(8'h3c, d, r);
        chk({30'h0, r}, {30'h0, RESP_ERR});
        $display("test reset done");
        axw(OFF_SLOT, 32'h23);
        axw(OFF_MASK, 32'h7ff);
        for (int i = 0; i < 9; i++)
            bus(ba(1'h0, 20'h80008), 6'h09, 8'ha0 + 8'(i), 1'h1, 1'h0, 1'h1);
        rdc(OFF_STAT, 32'h500);
        chk({31'h0, irq}, 32'h1);
        for (int i = 0; i < 8; i++)
            rdc(OFF_FIFO0, 32'h1a0 + 32'(i));
        bus(ba(1'h0, 20'h00004), 6'h09, 8'h11, 1'h1, 1'h0, 1'h0);
        bus(ba(1'h0, 20'h00008), 6'h39, 8'h12, 1'h1, 1'h0, 1'h0);
        axr(OFF_FIFO0, d, r);
        chk({31'h0, d[8]}, 32'h0);
        axw(OFF_LVL0 + 8'h04, 32'h20);
        bus(ba(1'h1, 20'h00008), 6'h09, 8'h5a, 1'h1, 1'h0, 1'h1);
        bus(ba(1'h1, 20'h00008), 6'h09, 8'h77, 1'h1, 1'h0, 1'h1);
        chk({29'h0, ipl}, 32'h2);
        rdc(OFF_FIFO1, 32'h15a);
        axr(OFF_FIFO1, d, r);
        chk({31'h0, d[8]}, 32'h0);
        axw(OFF_STAT, 32'h7ff);
        chk({31'h0, irq}, 32'h0);
        $display("test broadcast done");
        bus(MBX5, 6'h09, 8'h01, 1'h1, 1'h0, 1'h0);
        bus(MBX5, 6'h09, 8'h00, 1'h0, 1'h1, 1'h1);
        chk({24'h0, q}, 32'h0);
        bus(MBX5, 6'h09, 8'h01, 1'h1, 1'h1, 1'h1);
        rdc(OFF_STAT, 32'h20);
        bus(MBX5, 6'h09, 8'h00, 1'h0, 1'h1, 1'h1);
        chk({24'h0, q}, 32'h1);
        axw(OFF_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        axw(OFF_MASK, 32'h7ff);
        chk({31'h0, irq}, 32'h1);
        axw(OFF_LVL0, 32'h0060_0000);
        repeat (3) @(posedge clk);
        chk({29'h0, ipl}, 32'h6);
        iak(3'h6, VEC_INTERNAL, 8'h45);
        axw(OFF_VBASE, 32'h80);
        iak(3'h6, VEC_INTERNAL, 8'h85);
        $display("test mailbox done");
        axw(OFF_LVL0 + 8'h04, 32'h0007_0000);
        vmeIrqN <= 7'h7b;
        repeat (6) @(posedge clk);
        chk({29'h0, ipl}, 32'h7);
        iak(3'h7, VEC_VME, 8'h8c);
        vmeIrqN <= 7'h7f;
        axw(OFF_EXTV, 32'h1);
        axw(OFF_LVL0 + 8'h08, 32'h0000_3030);
        acFailN <= 1'h0;
        localIrq <= 23'h1;
        repeat (6) @(posedge clk);
        iak(3'h3, VEC_INTERNAL, 8'h91);
        acFailN <= 1'h1;
        repeat (6) @(posedge clk);
        iak(3'h3, VEC_LOCAL, 8'h93);
        axw(OFF_STAT, 32'h20);
        chk({31'h0, irq}, 32'h0);
        $display("test combiner done");
        wrapUp();
    end
    // the whole sequence needs well under a tenth of this span
    initial begin
        #3_000_000;
        failCount++;
        wrapUp();
    end
endmodule
`default_nettype wire
